// [logic/cid_alu.sv]
// Combinational result, flag and timing logic of the execution unit
`timescale 1ns/100ps
`include "cid_params.svh"
module cid_alu (
  // Instruction
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  input wire cid_pkg::flags_t flags_in,
  // Outcome
  output logic [15:0] result,
  output cid_pkg::flags_t flags_out,
  output logic taken,
  output logic [7:0] cycles,
  output logic legal
);
  import cid_pkg::*;

  logic [7:0] diff;
  logic [7:0] adj;
  logic [7:0] da_res;
  logic [7:0] byte_m1;
  logic [15:0] word_m1;
  logic da_c;

  always_comb begin
    diff = dst_val - src_val;
    byte_m1 = dst_val - 8'h01;
    word_m1 = {dst_val, src_val} - 16'h0001;
    adj = 8'h00;
    da_c = flags_in.c;
    if (!flags_in.d) begin
      if (flags_in.h || dst_val[3:0] > 4'h9) begin
        adj[3:0] = 4'h6;
      end
      if (flags_in.c || dst_val[7:4] > 4'h9 ||
          (dst_val[7:4] >= 4'h9 && dst_val[3:0] > 4'h9)) begin
        adj[7:4] = 4'h6;
        da_c = 1'b1;
      end
    end else begin
      case ({flags_in.c, flags_in.h})
        2'h1: begin
          adj = 8'hfa;
        end
        2'h2: begin
          adj = 8'ha0;
        end
        2'h3: begin
          adj = 8'h9a;
        end
        default: begin
          adj = 8'h00;
        end
      endcase
    end
    da_res = dst_val + adj;
    result = 16'h0000;
    flags_out = flags_in;
    taken = 1'b0;
    cycles = `CID_CYC_BAD;
    legal = 1'b1;
    case (opcode)
      `CID_OP_CMP_EQ: begin
        taken = diff == 8'h00;
        cycles = taken ? `CID_CYC_TAKEN : `CID_CYC_NOT_TAKEN;
      end
      `CID_OP_CMP_NE: begin
        taken = diff != 8'h00;
        cycles = taken ? `CID_CYC_TAKEN : `CID_CYC_NOT_TAKEN;
      end
      `CID_OP_DA_R, `CID_OP_DA_IR: begin
        result = {8'h00, da_res};
        flags_out.c = da_c;
        flags_out.z = da_res == 8'h00;
        flags_out.s = da_res[7];
        flags_out.v = 1'b0;
        cycles = `CID_CYC_BYTE;
      end
      `CID_OP_DEC_R, `CID_OP_DEC_IR: begin
        result = {8'h00, byte_m1};
        flags_out.z = byte_m1 == 8'h00;
        flags_out.s = byte_m1[7];
        flags_out.v = dst_val == 8'h80;
        cycles = `CID_CYC_BYTE;
      end
      `CID_OP_MINUS_ONE_WORD_RR, `CID_OP_MINUS_ONE_WORD_IR: begin
        result = word_m1;
        flags_out.z = word_m1 == 16'h0000;
        flags_out.s = word_m1[15];
        flags_out.v = {dst_val, src_val} == 16'h8000;
        cycles = `CID_CYC_WORD;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end
endmodule

// [logic/cid_params.svh]
// Constants for the compare, decimal adjust and decrement execution unit
// Operation
// - Equal compare subtracts src from dst, branches on zero, keeps flags.
// - Equal compare with nonzero difference falls through past the instruction.
// - Source pointer always increments by one before the next instruction.
// - Unequal compare branches on nonzero difference, falls through, keeps flags.
// - Unequal compare not taken resumes next and still increments pointer.
// - Both compare branches take 18 cycles taken, 16 cycles not taken.
// - Decimal adjust after add adds 00, 06, 60 or 66; carry per table.
// - Decimal adjust after subtract adds 00, FA, A0 or 9A; carry per table.
// - Decimal adjust sets zero and sign; keeps decimal and nibble flags.
// - Decimal adjust has direct and indirect forms, four cycles each.
// - Byte decrement lowers destination by one in four cycles.
// - Byte decrement sets zero, sign, overflow; keeps carry, decimal, nibble.
// - Word decrement lowers an even register pair by one in eight cycles.
// - Word decrement sets zero, sign, overflow from 16 bits; keeps others.
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CID_OFF_CTRL 8'h00
`define CID_OFF_OPER 8'h04
`define CID_OFF_PCFL 8'h08
`define CID_OFF_RES 8'h0c

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define CID_CTRL_START 8
`define CID_CTRL_BUSY 9
`define CID_CTRL_DONE 10
`define CID_CTRL_BAD 11

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define CID_OP_CMP_EQ 8'hc2
`define CID_OP_CMP_NE 8'hd2
`define CID_OP_DA_R 8'h40
`define CID_OP_DA_IR 8'h41
`define CID_OP_DEC_R 8'h00
`define CID_OP_DEC_IR 8'h01
`define CID_OP_MINUS_ONE_WORD_RR 8'h80
`define CID_OP_MINUS_ONE_WORD_IR 8'h81

// ----------------------------------------------------------------------
// Cycle counts (18, 16, 4, 8)
// ----------------------------------------------------------------------
`define CID_CYC_TAKEN 8'h12
`define CID_CYC_NOT_TAKEN 8'h10
`define CID_CYC_BYTE 8'h04
`define CID_CYC_WORD 8'h08
`define CID_CYC_BAD 8'h01

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CID_RST_BYTE 8'h00
`define CID_RST_PC 16'h0000
`define CID_RST_WORD 32'h0000_0000

`endif

// [logic/cid_pkg.sv]
// Types and opcode decoders for the execution unit
package cid_pkg;
  `include "cid_params.svh"

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic [1:0] spare;
  } flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_DONE = 2'h3
  } state_t;

  // ----------------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------------
  function automatic logic is_cmp(input logic [7:0] op);
    return op == `CID_OP_CMP_EQ || op == `CID_OP_CMP_NE;
  endfunction

  function automatic logic is_da(input logic [7:0] op);
    return op == `CID_OP_DA_R || op == `CID_OP_DA_IR;
  endfunction

  function automatic logic is_dec(input logic [7:0] op);
    return op == `CID_OP_DEC_R || op == `CID_OP_DEC_IR;
  endfunction

  function automatic logic is_minus_one_word(input logic [7:0] op);
    return op == `CID_OP_MINUS_ONE_WORD_RR || op == `CID_OP_MINUS_ONE_WORD_IR;
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction
endpackage

// [logic/cid_unit.sv]
// APB-controlled execution unit for compare, adjust and decrement
`timescale 1ns/100ps
`include "cid_params.svh"
module cid_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // APB request
  input wire cid_pkg::apb_req_t apb_req,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import cid_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  state_t state_q;
  logic [7:0] opcode_q;
  logic [7:0] a_q;
  logic [7:0] b_q;
  logic [7:0] ptr_q;
  logic [7:0] off_q;
  logic [15:0] pc_q;
  flags_t flags_q;
  logic [15:0] res_q;
  logic bad_q;
  logic [7:0] step_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic [15:0] alu_res;
  flags_t alu_flags;
  logic alu_taken;
  logic [7:0] alu_cycles;
  logic alu_legal;

  logic setup;
  logic wr_fire;
  logic start_ok;
  logic commit;
  logic idle_wr;

  function automatic logic mapped(input logic [7:0] addr);
    return addr == `CID_OFF_CTRL || addr == `CID_OFF_OPER ||
           addr == `CID_OFF_PCFL || addr == `CID_OFF_RES;
  endfunction

  cid_alu u_alu (
    .opcode(opcode_q),
    .dst_val(a_q),
    .src_val(b_q),
    .flags_in(flags_q),
    .result(alu_res),
    .flags_out(alu_flags),
    .taken(alu_taken),
    .cycles(alu_cycles),
    .legal(alu_legal)
  );

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                   pready_q && ce;
  // Operands are frozen while running so the result matches its inputs
  assign idle_wr = wr_fire && state_q != ST_RUN;
  assign start_ok = idle_wr && apb_req.paddr == `CID_OFF_CTRL &&
                    apb_req.pwdata[`CID_CTRL_START];
  assign commit = ce && state_q == ST_RUN &&
                  step_q == alu_cycles - 8'h01;

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped(apb_req.paddr);
    end
  end

  // Read data is captured in setup, so a commit in the same edge is not seen
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= `CID_RST_WORD;
    end else if (ce && setup) begin
      case (apb_req.paddr)
        `CID_OFF_CTRL: begin
          prdata_q <= {20'h00000, bad_q, state_q == ST_DONE,
                       state_q == ST_RUN, 1'b0, opcode_q};
        end
        `CID_OFF_OPER: begin
          prdata_q <= {off_q, ptr_q, b_q, a_q};
        end
        `CID_OFF_PCFL: begin
          prdata_q <= {8'h00, flags_q, pc_q};
        end
        `CID_OFF_RES: begin
          prdata_q <= {16'h0000, res_q};
        end
        default: begin
          prdata_q <= `CID_RST_WORD;
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (start_ok) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (commit) begin
            state_q <= ST_DONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      step_q <= `CID_RST_BYTE;
    end else if (ce) begin
      if (state_q == ST_RUN && !commit) begin
        step_q <= step_q + 8'h01;
      end else begin
        step_q <= `CID_RST_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      opcode_q <= `CID_RST_BYTE;
      a_q <= `CID_RST_BYTE;
      b_q <= `CID_RST_BYTE;
      off_q <= `CID_RST_BYTE;
    end else if (idle_wr) begin
      if (apb_req.paddr == `CID_OFF_CTRL) begin
        opcode_q <= apb_req.pwdata[7:0];
      end
      if (apb_req.paddr == `CID_OFF_OPER) begin
        a_q <= apb_req.pwdata[7:0];
        b_q <= apb_req.pwdata[15:8];
        off_q <= apb_req.pwdata[31:24];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_q <= `CID_RST_BYTE;
    end else if (commit && is_cmp(opcode_q)) begin
      ptr_q <= ptr_q + 8'h01;
    end else if (idle_wr && apb_req.paddr == `CID_OFF_OPER) begin
      ptr_q <= apb_req.pwdata[23:16];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pc_q <= `CID_RST_PC;
    end else if (commit && is_cmp(opcode_q) && alu_taken) begin
      pc_q <= pc_q + sext8(off_q);
    end else if (idle_wr && apb_req.paddr == `CID_OFF_PCFL) begin
      pc_q <= apb_req.pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_q <= `CID_RST_BYTE;
    end else if (commit && !is_cmp(opcode_q) && alu_legal) begin
      flags_q <= alu_flags;
    end else if (idle_wr && apb_req.paddr == `CID_OFF_PCFL) begin
      flags_q <= apb_req.pwdata[23:16];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      res_q <= `CID_RST_PC;
      bad_q <= 1'b0;
    end else if (commit) begin
      bad_q <= !alu_legal;
      if (!is_cmp(opcode_q) && alu_legal) begin
        res_q <= alu_res;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic [7:0] run_cnt_q;
  logic [7:0] exp_cyc;

  always_ff @(posedge clk) begin
    if (reset || state_q != ST_RUN) begin
      run_cnt_q <= `CID_RST_BYTE;
    end else if (ce) begin
      run_cnt_q <= run_cnt_q + 8'h01;
    end
  end

  always_comb begin
    exp_cyc = `CID_CYC_BAD;
    if (opcode_q == `CID_OP_CMP_EQ) begin
      exp_cyc = a_q == b_q ? `CID_CYC_TAKEN : `CID_CYC_NOT_TAKEN;
    end else if (opcode_q == `CID_OP_CMP_NE) begin
      exp_cyc = a_q != b_q ? `CID_CYC_TAKEN : `CID_CYC_NOT_TAKEN;
    end else if (is_da(opcode_q) || is_dec(opcode_q)) begin
      exp_cyc = `CID_CYC_BYTE;
    end else if (is_minus_one_word(opcode_q)) begin
      exp_cyc = `CID_CYC_WORD;
    end
  end

  property p_eq_taken;
    commit && opcode_q == `CID_OP_CMP_EQ && a_q == b_q |=>
      pc_q == $past(pc_q) + sext8($past(off_q));
  endproperty
  a_eq_taken: assert property (p_eq_taken)
    else $error("equal compare did not branch");

  property p_eq_fall;
    commit && opcode_q == `CID_OP_CMP_EQ && a_q != b_q |=>
      pc_q == $past(pc_q);
  endproperty
  a_eq_fall: assert property (p_eq_fall)
    else $error("equal compare moved pc on mismatch");

  property p_ptr_flags;
    commit && is_cmp(opcode_q) |=>
      ptr_q == $past(ptr_q) + 8'h01 && flags_q == $past(flags_q);
  endproperty
  a_ptr_flags: assert property (p_ptr_flags)
    else $error("compare pointer or flags wrong");

  property p_ne_branch;
    commit && opcode_q == `CID_OP_CMP_NE |=>
      pc_q == ($past(a_q) != $past(b_q) ?
               $past(pc_q) + sext8($past(off_q)) : $past(pc_q));
  endproperty
  a_ne_branch: assert property (p_ne_branch)
    else $error("unequal compare branch wrong");

  property p_ne_fall;
    commit && opcode_q == `CID_OP_CMP_NE && a_q == b_q |=>
      pc_q == $past(pc_q) && ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_ne_fall: assert property (p_ne_fall)
    else $error("unequal compare moved pc on match");

  property p_cycles;
    commit |-> run_cnt_q == exp_cyc - 8'h01;
  endproperty
  a_cycles: assert property (p_cycles)
    else $error("instruction length wrong");

  property p_byte_len;
    commit && (is_da(opcode_q) || is_dec(opcode_q)) |->
      run_cnt_q == `CID_CYC_BYTE - 8'h01;
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("byte instruction length wrong");

  property p_word_len;
    commit && is_minus_one_word(opcode_q) |-> run_cnt_q == `CID_CYC_WORD - 8'h01;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("word decrement length wrong");

  property p_da_add;
    commit && is_da(opcode_q) && !flags_q.d && !flags_q.c &&
      !flags_q.h && a_q[7:4] < 4'h9 && a_q[3:0] > 4'h9 |=>
      res_q[7:0] == $past(a_q) + 8'h06 && !flags_q.c;
  endproperty
  a_da_add: assert property (p_da_add)
    else $error("add adjust wrong");

  property p_da_sub;
    commit && is_da(opcode_q) && flags_q.d && flags_q.c && flags_q.h |=>
      res_q[7:0] == $past(a_q) + 8'h9a && flags_q.c;
  endproperty
  a_da_sub: assert property (p_da_sub)
    else $error("subtract adjust wrong");

  property p_da_flags;
    commit && is_da(opcode_q) |=>
      flags_q.z == (res_q[7:0] == 8'h00) && flags_q.s == res_q[7] &&
      flags_q.d == $past(flags_q.d) && flags_q.h == $past(flags_q.h);
  endproperty
  a_da_flags: assert property (p_da_flags)
    else $error("adjust flags wrong");

  property p_dec;
    commit && is_dec(opcode_q) |=>
      res_q[7:0] == $past(a_q) - 8'h01 && flags_q.c == $past(flags_q.c) &&
      flags_q.v == ($past(a_q) == 8'h80);
  endproperty
  a_dec: assert property (p_dec)
    else $error("byte decrement wrong");

  property p_minus_one_word;
    commit && is_minus_one_word(opcode_q) |=>
      res_q == {$past(a_q), $past(b_q)} - 16'h0001 &&
      flags_q.z == (res_q == 16'h0000) && flags_q.c == $past(flags_q.c);
  endproperty
  a_minus_one_word: assert property (p_minus_one_word)
    else $error("word decrement wrong");

  c_eq_taken: cover property (commit && opcode_q == `CID_OP_CMP_EQ &&
                              alu_taken);
  c_ne_fall: cover property (commit && opcode_q == `CID_OP_CMP_NE &&
                             !alu_taken);
  c_da: cover property (commit && is_da(opcode_q) && flags_q.d);
  c_minus_one_word: cover property (commit && is_minus_one_word(opcode_q));
endmodule

// [verification/cid_host.sv]
// Bus-master model that issues single register transfers
`timescale 1ns/100ps
module cid_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Transfer request from the bench
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  // Slave answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Bus and outcome
  output cid_pkg::apb_req_t apb_req,
  output logic [31:0] rdata,
  output logic err,
  output logic done
);
  import cid_pkg::*;

  // ----
  // Transfer sequencing
  // ----
  always_ff @(posedge clk) begin
    if (reset) begin
      apb_req <= '0;
      rdata <= 32'h0;
      err <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!apb_req.psel && go) begin
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wdata;
      end else if (apb_req.psel && !apb_req.penable) begin
        apb_req.penable <= 1'b1;
      end else if (apb_req.penable && pready) begin
        rdata <= prdata;
        err <= pslverr;
        done <= 1'b1;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        // Released lines change, so stale values cannot pass
        apb_req.pwdata <= ~apb_req.pwdata;
        apb_req.paddr <= ~apb_req.paddr;
      end
    end
  end
endmodule

// [verification/cid_unit_bench.sv]
// Random and corner-case bench for the execution unit
`timescale 1ns/100ps
`include "cid_params.svh"
module cid_unit_bench;
  import cid_pkg::*;

  // ----
  // Signals
  // ----
  logic clk;
  logic reset;
  logic ce;
  logic go;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic err;
  logic done;
  apb_req_t apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int cyc = 0;
  int err_count = 0;
  int checks = 0;
  logic [7:0] ops [9];

  cid_unit cid_unit_i (.clk(clk), .reset(reset), .ce(ce),
    .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  cid_host cid_host_i (.clk(clk), .reset(reset), .go(go), .wr(wr),
    .addr(addr), .wdata(wdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .apb_req(apb_req), .rdata(rdata), .err(err),
    .done(done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t error flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    // A missing answer is ended by the hang guard alone
    do begin
      @(posedge clk);
    end while (done !== 1'b1);
  endtask

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  task automatic run_op(input logic [7:0] op, input logic [7:0] dst,
      input logic [7:0] src, input logic [7:0] ptr, input logic [7:0] off,
      input logic [15:0] pc, input flags_t fl, input logic [8:0] dx);
    logic [15:0] res;
    logic [15:0] pc_x;
    logic [7:0] ptr_x;
    flags_t fx;
    logic tk;
    int n;
    int e;
    res = 16'h0000;
    pc_x = pc;
    ptr_x = ptr;
    fx = fl;
    n = 1;
    case (op)
      `CID_OP_CMP_EQ, `CID_OP_CMP_NE: begin
        tk = ((dst == src) == (op == `CID_OP_CMP_EQ));
        pc_x = tk ? pc + {{8{off[7]}}, off} : pc;
        ptr_x = ptr + 8'h01;
        n = tk ? 18 : 16;
      end
      `CID_OP_DA_R, `CID_OP_DA_IR: begin
        res = {8'h00, dx[7:0]};
        fx.c = dx[8];
        fx.z = (dx[7:0] == 8'h00);
        fx.s = dx[7];
        fx.v = 1'b0;
        n = 4;
      end
      `CID_OP_DEC_R, `CID_OP_DEC_IR: begin
        res = {8'h00, dst - 8'h01};
        fx.z = (dst == 8'h01);
        fx.s = res[7];
        fx.v = (dst == 8'h80);
        n = 4;
      end
      `CID_OP_MINUS_ONE_WORD_RR, `CID_OP_MINUS_ONE_WORD_IR: begin
        res = {dst, src} - 16'h0001;
        fx.z = ({dst, src} == 16'h0001);
        fx.s = res[15];
        fx.v = ({dst, src} == 16'h8000);
        n = 8;
      end
      default: n = 1;
    endcase
    bus(1'b1, `CID_OFF_PCFL, {8'h00, fl, pc});
    bus(1'b1, `CID_OFF_OPER, {off, ptr, src, dst});
    bus(1'b1, `CID_OFF_CTRL, {23'h0, 1'b1, op});
    e = cyc;
    // Writes while busy must be dropped
    if (n >= 8) begin
      bus(1'b1, `CID_OFF_OPER, 32'hffff_ffff);
    end
    // Sample the last busy edge, then a later finished one
    if (n > 1) begin
      while (cyc < e + n - 3) @(posedge clk);
      bus(1'b0, `CID_OFF_CTRL, 32'h0);
      check_word({30'h0, rdata[10:9]}, 32'h1);
    end
    bus(1'b0, `CID_OFF_CTRL, 32'h0);
    check_word({20'h0, rdata[11:0]}, {20'h0, n == 1, 3'b100, op});
    bus(1'b0, `CID_OFF_PCFL, 32'h0);
    check_word({8'h00, rdata[23:0]}, {8'h00, fx, pc_x});
    bus(1'b0, `CID_OFF_OPER, 32'h0);
    check_word({24'h0, rdata[23:16]}, {24'h0, ptr_x});
    if (n == 4 || n == 8) begin
      bus(1'b0, `CID_OFF_RES, 32'h0);
      check_word({16'h0, rdata[15:0]}, {16'h0, res});
    end
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    logic [7:0] op;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] ba;
    logic [7:0] bb;
    logic [8:0] dx;
    flags_t fl;
    int av;
    int bv;
    void'($urandom(32'h5a8c));
    reset = 1'b1;
    ce = 1'b1;
    go = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    ops = '{8'hc2, 8'hd2, 8'h40, 8'h41, 8'h00, 8'h01, 8'h80, 8'h81, 8'hff};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check_word(rdata, 32'h0);
    end
    // Unmapped place and read-only result
    bus(1'b0, 8'h10, 32'h0);
    check_bit(err, 1'b1);
    check_word(rdata, 32'h0);
    bus(1'b1, `CID_OFF_RES, 32'h1234_5678);
    check_bit(err, 1'b0);
    bus(1'b0, `CID_OFF_RES, 32'h0);
    check_word(rdata, 32'h0);
    // Boundary operands; offsets at both range ends
    run_op(8'h00, 8'h80, 8'h00, 8'h10, 8'h00, 16'h0100, 8'hff, 9'h0);
    run_op(8'h01, 8'h01, 8'h00, 8'h10, 8'h00, 16'h0100, 8'h00, 9'h0);
    run_op(8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 16'h0100, 8'h48, 9'h0);
    // dst holds the upper byte of an even pair
    run_op(8'h80, 8'h80, 8'h00, 8'h10, 8'h00, 16'h0100, 8'h00, 9'h0);
    run_op(8'h81, 8'h00, 8'h01, 8'h10, 8'h00, 16'h0100, 8'hff, 9'h0);
    run_op(8'h80, 8'h00, 8'h00, 8'h10, 8'h00, 16'h0100, 8'h2c, 9'h0);
    run_op(8'hc2, 8'h42, 8'h42, 8'hff, 8'h80, 16'h0010, 8'ha4, 9'h0);
    run_op(8'hd2, 8'h42, 8'h43, 8'h03, 8'h7f, 16'hfff0, 8'h5b, 9'h0);
    run_op(8'hc2, 8'h42, 8'h43, 8'h03, 8'h7f, 16'h1234, 8'h00, 9'h0);
    run_op(8'hd2, 8'h42, 8'h42, 8'h03, 8'h7f, 16'h1234, 8'hff, 9'h0);
    run_op(8'hff, 8'h42, 8'h42, 8'h03, 8'h7f, 16'h1234, 8'h00, 9'h0);
    for (int i = 0; i < 80; i++) begin
      op = ops[$urandom_range(8)];
      dst = 8'($urandom);
      src = 8'($urandom);
      fl = flags_t'(8'($urandom));
      dx = 9'h0;
      if ($urandom_range(1) == 1) begin
        src = dst;
      end
      av = $urandom_range(99);
      bv = $urandom_range(99);
      ba = bcd(av);
      bb = bcd(bv);
      if (op[7:1] == 7'h20 && fl.d) begin
        dst = ba - bb;
        fl.c = (av < bv);
        fl.h = (ba[3:0] < bb[3:0]);
        dx = {av < bv, bcd((av - bv + 100) % 100)};
      end else if (op[7:1] == 7'h20) begin
        {fl.c, dst} = {1'b0, ba} + {1'b0, bb};
        fl.h = ({1'b0, ba[3:0]} + {1'b0, bb[3:0]}) > 5'h0f;
        dx = {av + bv > 99, bcd((av + bv) % 100)};
      end
      run_op(op, dst, src, 8'($urandom), 8'($urandom), 16'($urandom),
             fl, dx);
    end
    summarize();
  end
endmodule
